// *** hw/aicd_decoder.sv ***
// Purpose: Decode the analog input fields of the setup word into mux controls
// Assumes: Setup word and load strobe come from logic on mclk_i; the trigger pin is external
// Notes: New setup takes effect at the next acquisition; the active set is frozen in conversion
`timescale 1ns/1ps

// Behaviour
// RL1 - One setup bit picks full or quarter filter bandwidth.
// RL2 - Host slows conversion rate to a quarter when quarter bandwidth is chosen.
// RL3 - Code 111: every input single-ended against ground.
// RL4 - Code 010: each input against common input at half reference, bipolar.
// RL5 - Code 110: each input against common input as ground sense, unipolar.
// RL6 - Code 00X: adjacent pairs, bipolar, negative member at half reference.
// RL7 - Code 10X: adjacent pairs, unipolar, negative member as ground sense.
// RL8 - Channel field picks pair; its parity picks the positive member.
// RL9 - During sequencer pair scan, even inputs are always positive.
// RL10 - Bipolar configurations give two's complement results.
// RL11 - Each conversion may use a different input configuration.
// RL12 - Unipolar configurations give straight binary results.
// RL13 - New setup applies from next acquisition, never mid-conversion.
module aicd_decoder #(
   parameter int NUM_INPUTS = aicd_pkg::NUM_IN
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic [aicd_pkg::WORD_W-1:0] setup_word_i,
   input wire logic setup_load_i,
   input wire logic seq_pair_scan_i,
   input wire logic conversion_trigger_i,
   input wire logic conv_done_i,
   output logic filter_bandwidth_select_o,
   output logic [aicd_pkg::CHAN_W-1:0] positive_input_member_o,
   output logic [aicd_pkg::CHAN_W-1:0] negative_input_member_o,
   output logic neg_is_com_o,
   output logic neg_is_gnd_o,
   output logic bipolar_o,
   output logic twos_comp_o,
   output logic converting_o,
   output logic [2:0] mode_o
);

   if (NUM_INPUTS != 8) begin : g_chk
      $error("aicd_decoder serves exactly eight inputs");
   end

   function automatic aicd_pkg::aicd_mode_type decode_mode(input logic [2:0] cc);
      aicd_pkg::aicd_mode_type m;
      m = aicd_pkg::AICD_MODE_RSVD;
      if (cc == aicd_pkg::INCC_SINGLE) begin
         m = aicd_pkg::AICD_MODE_SINGLE; // [RL3]
      end else if (cc == aicd_pkg::INCC_COM_BIP) begin
         m = aicd_pkg::AICD_MODE_COM_BIP; // [RL4]
      end else if (cc == aicd_pkg::INCC_COM_UNI) begin
         m = aicd_pkg::AICD_MODE_COM_UNI; // [RL5]
      end else if (cc[2:1] == aicd_pkg::INCC_PAIR_BIP) begin
         m = aicd_pkg::AICD_MODE_PAIR_BIP; // [RL6]
      end else if (cc[2:1] == aicd_pkg::INCC_PAIR_UNI) begin
         m = aicd_pkg::AICD_MODE_PAIR_UNI; // [RL7]
      end
      return m;
   endfunction

   function automatic logic mode_is_pair(input aicd_pkg::aicd_mode_type m);
      return (m == aicd_pkg::AICD_MODE_PAIR_BIP) || (m == aicd_pkg::AICD_MODE_PAIR_UNI);
   endfunction

   function automatic logic mode_is_bip(input aicd_pkg::aicd_mode_type m);
      return (m == aicd_pkg::AICD_MODE_PAIR_BIP) || (m == aicd_pkg::AICD_MODE_COM_BIP);
   endfunction

   // Trigger pin synchroniser; the second and third stages feed the rising-edge detect
   logic trig_s1_q, trig_s2_q, trig_s3_q;
   logic trig_rise;

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         trig_s1_q <= 1'b0;
         trig_s2_q <= 1'b0;
         trig_s3_q <= 1'b0;
      end else begin
         trig_s1_q <= conversion_trigger_i;
         trig_s2_q <= trig_s1_q;
         trig_s3_q <= trig_s2_q;
      end
   end

   assign trig_rise = trig_s2_q && !trig_s3_q;

   // Pending word holds the host's latest write until the next acquisition
   logic [aicd_pkg::WORD_W-1:0] pend_q, pend_d;
   logic [aicd_pkg::WORD_W-1:0] act_q, act_d;
   logic seqp_q, seqp_d;
   aicd_pkg::aicd_state_type st_q, st_d;

   always_comb begin
      pend_d = pend_q;
      act_d = act_q;
      seqp_d = seqp_q;
      st_d = st_q;
      if (setup_load_i) begin
         pend_d = setup_word_i; // [RL11]
      end
      case (st_q)
         aicd_pkg::AICD_ST_ACQ: begin
            // Acquisition: latest setup drives the mux so the input settles
            act_d = setup_load_i ? setup_word_i : pend_q; // [RL13]
            seqp_d = seq_pair_scan_i;
            if (trig_rise) begin
               st_d = aicd_pkg::AICD_ST_CONV;
            end
         end
         aicd_pkg::AICD_ST_CONV: begin
            // Frozen: a write here waits in pend_q
            if (conv_done_i) begin
               st_d = aicd_pkg::AICD_ST_ACQ; // [RL13]
            end
         end
         default: begin
            st_d = aicd_pkg::AICD_ST_ACQ;
         end
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pend_q <= aicd_pkg::SETUP_RESET;
         act_q <= aicd_pkg::SETUP_RESET;
         seqp_q <= 1'b0;
         st_q <= aicd_pkg::AICD_ST_ACQ;
      end else begin
         pend_q <= pend_d;
         act_q <= act_d;
         seqp_q <= seqp_d;
         st_q <= st_d;
      end
   end

   // Output decode of the active word, registered
   aicd_pkg::aicd_mode_type mode_a;
   logic [aicd_pkg::CHAN_W-1:0] chan_a;
   logic [aicd_pkg::CHAN_W-1:0] pos_d, neg_d;
   logic pair_a, bip_a;
   logic bw_d, com_d, gnd_d, conv_d;

   always_comb begin
      mode_a = decode_mode(act_q[aicd_pkg::INCC_HI:aicd_pkg::INCC_LO]);
      chan_a = act_q[aicd_pkg::CHAN_HI:aicd_pkg::CHAN_LO];
      pair_a = mode_is_pair(mode_a);
      bip_a = mode_is_bip(mode_a); // [RL10] [RL12]
      bw_d = act_q[aicd_pkg::BW_BIT]; // [RL1]
      // Busy follows the state's next value so converting_o rises and falls with st_q, not a cycle later
      conv_d = (st_d == aicd_pkg::AICD_ST_CONV);
      pos_d = chan_a;
      neg_d = chan_a;
      com_d = 1'b0;
      gnd_d = 1'b0;
      if (pair_a) begin
         // Pair partner is the other input of the even/odd pair
         if (seqp_q) begin
            pos_d = {chan_a[2:1], 1'b0}; // [RL9]
         end else begin
            pos_d = chan_a; // [RL8]
         end
         neg_d = {pos_d[2:1], ~pos_d[0]}; // [RL8]
      end else if (mode_a == aicd_pkg::AICD_MODE_SINGLE) begin
         gnd_d = 1'b1; // [RL3]
      end else begin
         com_d = 1'b1; // [RL4] [RL5]
      end
   end

   logic bw_q, com_q, gnd_q, bip_q, conv_q;
   logic [aicd_pkg::CHAN_W-1:0] pos_q, neg_q;
   logic [2:0] mode_q;

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bw_q <= 1'b0;
         com_q <= 1'b0;
         gnd_q <= 1'b1;
         bip_q <= 1'b0;
         conv_q <= 1'b0;
         pos_q <= '0;
         neg_q <= '0;
         mode_q <= 3'h0;
      end else begin
         bw_q <= bw_d;
         com_q <= com_d;
         gnd_q <= gnd_d;
         bip_q <= bip_a;
         conv_q <= conv_d;
         pos_q <= pos_d;
         neg_q <= neg_d;
         mode_q <= mode_a;
      end
   end

   assign filter_bandwidth_select_o = bw_q;
   assign positive_input_member_o = pos_q;
   assign negative_input_member_o = neg_q;
   assign neg_is_com_o = com_q;
   assign neg_is_gnd_o = gnd_q;
   assign bipolar_o = bip_q;
   assign twos_comp_o = bip_q;
   assign converting_o = conv_q;
   assign mode_o = mode_q;

   // Checks
   localparam int CONV_MAX = 8;

   mode_bip_fmt_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RL10]
      (mode_o == 3'b001 || mode_o == 3'b011) |-> twos_comp_o)
      else $error("bipolar mode without twos complement");
   mode_uni_fmt_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RL12]
      (mode_o == 3'b000 || mode_o == 3'b010 || mode_o == 3'b100) |-> !twos_comp_o)
      else $error("unipolar mode not straight binary");
   single_gnd_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RL3]
      (mode_o == 3'b000) |-> (neg_is_gnd_o && !neg_is_com_o))
      else $error("single-ended not against ground");
   com_mode_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RL4]
      (mode_o == 3'b001 || mode_o == 3'b010) |-> (neg_is_com_o && !neg_is_gnd_o))
      else $error("common mode not against common input");
   pair_neg_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RL8]
      (mode_o == 3'b011 || mode_o == 3'b100)
      |-> (negative_input_member_o == (positive_input_member_o ^ 3'h1)))
      else $error("pair negative member wrong");
   seq_even_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RL9]
      (seqp_q && $stable(act_q)
      && mode_is_pair(decode_mode(act_q[aicd_pkg::INCC_HI:aicd_pkg::INCC_LO])))
      |=> !positive_input_member_o[0])
      else $error("sequencer pair not even positive");
   bw_follow_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RL1]
      1'b1 |=> (filter_bandwidth_select_o == $past(act_q[aicd_pkg::BW_BIT])))
      else $error("bandwidth output lags active word");
   conv_freeze_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RL13]
      (st_q == aicd_pkg::AICD_ST_CONV) |=> (act_q == $past(act_q)))
      else $error("active setup changed mid-conversion");
   trig_start_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RL13]
      (st_q == aicd_pkg::AICD_ST_ACQ && trig_rise) |=> converting_o)
      else $error("conversion did not start");

   // Paired mode without the sequencer keeps the host's channel as positive
   pair_pos_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RL8]
      (!seqp_q && mode_is_pair(decode_mode(act_q[aicd_pkg::INCC_HI:aicd_pkg::INCC_LO])))
      |=> (positive_input_member_o == $past(act_q[aicd_pkg::CHAN_HI:aicd_pkg::CHAN_LO])))
      else $error("pair positive member wrong");

   bip_mode_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RL10]
      bipolar_o |-> (mode_o == aicd_pkg::AICD_MODE_COM_BIP
      || mode_o == aicd_pkg::AICD_MODE_PAIR_BIP))
      else $error("bipolar flag outside bipolar modes");

   conv_end_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RL13]
      (st_q == aicd_pkg::AICD_ST_CONV && conv_done_i) |=> !converting_o)
      else $error("conversion did not end");

   // A second trigger while busy must not disturb the running conversion
   conv_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RL13]
      (st_q == aicd_pkg::AICD_ST_CONV && !conv_done_i) |=> converting_o)
      else $error("conversion dropped early");

   acq_load_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RL11]
      (st_q == aicd_pkg::AICD_ST_ACQ && setup_load_i) |=> (act_q == $past(setup_word_i)))
      else $error("acquisition load not applied");

   pend_keep_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RL13]
      (st_q == aicd_pkg::AICD_ST_CONV && setup_load_i) |=> (pend_q == $past(setup_word_i)))
      else $error("mid-conversion load lost");

   pair_bip_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RL6]
      (act_q[aicd_pkg::INCC_HI:aicd_pkg::INCC_HI-1] == aicd_pkg::INCC_PAIR_BIP)
      |=> (mode_o == aicd_pkg::AICD_MODE_PAIR_BIP && bipolar_o))
      else $error("bipolar pair not decoded");

   pair_uni_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RL7]
      (act_q[aicd_pkg::INCC_HI:aicd_pkg::INCC_HI-1] == aicd_pkg::INCC_PAIR_UNI)
      |=> (mode_o == aicd_pkg::AICD_MODE_PAIR_UNI && !bipolar_o))
      else $error("unipolar pair not decoded");

   com_uni_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RL5]
      (act_q[aicd_pkg::INCC_HI:aicd_pkg::INCC_LO] == aicd_pkg::INCC_COM_UNI)
      |=> (neg_is_com_o && !bipolar_o))
      else $error("unipolar common input not decoded");

   com_bip_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RL4]
      (act_q[aicd_pkg::INCC_HI:aicd_pkg::INCC_LO] == aicd_pkg::INCC_COM_BIP)
      |=> (neg_is_com_o && bipolar_o))
      else $error("bipolar common input not decoded");

   cov_seq_scan_c: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
      seqp_q && (mode_o == aicd_pkg::AICD_MODE_PAIR_UNI));

   cov_pair_odd_c: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
      (mode_o == 3'b011) && positive_input_member_o[0]);
   cov_load_conv_c: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
      (st_q == aicd_pkg::AICD_ST_CONV) && setup_load_i);
   cov_mode_switch_c: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
      (mode_o == 3'b000) ##[1:CONV_MAX] (mode_o == 3'b001));
   cov_quarter_c: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
      filter_bandwidth_select_o && converting_o);

endmodule

// *** hw/aicd_pkg.sv ***
// Purpose: Shared constants for the analog input configuration decoder
// Assumes: 14-bit setup word, 8 analog inputs, 3-bit mux select
// Notes: Field positions follow the setup word layout
package aicd_pkg;
   localparam int WORD_W = 14;
   localparam int CHAN_W = 3;
   localparam int NUM_IN = 8;
   // Setup word field positions
   localparam int BW_BIT = 6;
   localparam int CHAN_LO = 7;
   localparam int CHAN_HI = 9;
   localparam int INCC_LO = 10;
   localparam int INCC_HI = 12;
   // Input configuration codes
   localparam logic [2:0] INCC_SINGLE = 3'h7;
   localparam logic [2:0] INCC_COM_BIP = 3'h2;
   localparam logic [2:0] INCC_COM_UNI = 3'h6;
   localparam logic [1:0] INCC_PAIR_BIP = 2'h0;
   localparam logic [1:0] INCC_PAIR_UNI = 2'h2;
   // Reset: full bandwidth, single-ended, channel 0
   localparam logic [WORD_W-1:0] SETUP_RESET = 14'h1c00;

   typedef enum logic [2:0] {
      AICD_MODE_SINGLE = 3'b000,
      AICD_MODE_COM_BIP = 3'b001,
      AICD_MODE_COM_UNI = 3'b010,
      AICD_MODE_PAIR_BIP = 3'b011,
      AICD_MODE_PAIR_UNI = 3'b100,
      AICD_MODE_RSVD = 3'b101
   } aicd_mode_type;

   typedef enum logic [1:0] {
      AICD_ST_ACQ = 2'b00,
      AICD_ST_CONV = 2'b01
   } aicd_state_type;
endpackage

// *** test/aicd_host.sv ***
// Purpose: Host model that writes setup words and fires the conversion trigger pin
// Assumes: Bench requests arrive on mclk_i
// Notes: Trigger hold-off count grows fourfold once quarter bandwidth is loaded
`timescale 1ns/1ps
module aicd_host #(
   parameter int GAP = 2
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic load_req_i,
   input wire logic [13:0] word_i,
   input wire logic conv_req_i,
   output logic [13:0] setup_word_o,
   output logic setup_load_o,
   output logic trig_o
);
   logic quarter_q;
   int hold_q;
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         setup_word_o <= 14'h0000;
         setup_load_o <= 1'b0;
         trig_o <= 1'b0;
         quarter_q <= 1'b0;
         hold_q <= 0;
      end else begin
         setup_load_o <= load_req_i;
         // Word is junk outside a load, so a stale capture shows up
         setup_word_o <= load_req_i ? word_i : ~setup_word_o;
         if (load_req_i) begin
            quarter_q <= word_i[aicd_pkg::BW_BIT];
         end
         trig_o <= conv_req_i && hold_q == 0;
         if (conv_req_i && hold_q == 0) begin
            // Slow filter needs four times the acquisition time
            hold_q <= quarter_q ? 4 * GAP : GAP;
         end else if (hold_q > 0) begin
            hold_q <= hold_q - 1;
         end
      end
   end
endmodule

// *** test/test_adc_input_config_decoder.sv ***
// Purpose: Self-checking bench for the input configuration decoder
// Assumes: Host model drives the setup port and trigger pin
// Notes: Outputs checked four edges after a load request
`timescale 1ns/1ps
module test_adc_input_config_decoder;
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic load_req = 1'b0;
   logic conv_req = 1'b0;
   logic [13:0] word = 14'h0000;
   logic scan = 1'b0;
   logic done = 1'b0;
   logic [13:0] s_word;
   logic s_load, trig, bw, com, gnd, bip, twos, conv;
   logic [2:0] pos, neg, mode;
   int n_fail = 0;
   int n_tests = 0;
   int seed = 32'haaba;
   int k;
   logic [13:0] w;
   always #12.5 mclk_i = ~mclk_i;
   aicd_host host (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .load_req_i(load_req),
      .word_i(word), .conv_req_i(conv_req), .setup_word_o(s_word),
      .setup_load_o(s_load), .trig_o(trig));
   aicd_decoder uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .setup_word_i(s_word),
      .setup_load_i(s_load), .seq_pair_scan_i(scan), .conversion_trigger_i(trig),
      .conv_done_i(done), .filter_bandwidth_select_o(bw),
      .positive_input_member_o(pos), .negative_input_member_o(neg),
      .neg_is_com_o(com), .neg_is_gnd_o(gnd), .bipolar_o(bip),
      .twos_comp_o(twos), .converting_o(conv), .mode_o(mode));
   // Packed as mode, positive, com, gnd, bipolar, twos, bandwidth
   function automatic logic [10:0] expect_of(input logic [13:0] v, input logic sc);
      logic [2:0] c;
      logic [2:0] p;
      logic [2:0] m;
      c = v[12:10];
      p = v[9:7];
      m = (c == 3'h7) ? 3'h0 : (c == 3'h2) ? 3'h1 : (c == 3'h6) ? 3'h2 :
         (c[2:1] == 2'h0) ? 3'h3 : (c[2:1] == 2'h2) ? 3'h4 : 3'h5;
      if (sc && (m == 3'h3 || m == 3'h4)) begin
         p = p & 3'h6;
      end
      return {m, p, m == 3'h1 || m == 3'h2 || m == 3'h5, m == 3'h0,
         m == 3'h1 || m == 3'h3, m == 3'h1 || m == 3'h3, v[6]};
   endfunction
   task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic load(input logic [13:0] v, input logic sc);
      @(posedge mclk_i);
      word <= v;
      scan <= sc;
      load_req <= 1'b1;
      @(posedge mclk_i);
      load_req <= 1'b0;
   endtask
   task automatic verify(input logic [13:0] v);
      logic [10:0] e;
      e = expect_of(v, scan);
      repeat (4) @(posedge mclk_i);
      #1;
      check("decode", {mode, pos, com, gnd, bip, twos, bw}, e);
      if (e[10:8] == 3'h3 || e[10:8] == 3'h4) begin
         check("negative", 11'(neg), 11'(e[7:5] ^ 3'h1));
      end else begin
         check("negative", 11'(neg), 11'(e[7:5]));
      end
   endtask
   initial begin
      repeat (6) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      #1;
      check("reset", {mode, pos, com, gnd, bip, twos, bw}, expect_of(14'h1c00, 1'b0));
      // Every code three times, the middle pass with pair scanning on
      for (k = 0; k < 24; k++) begin
         w = 14'($random(seed));
         w[12:10] = 3'(k);
         load(w, k[3]);
         verify(w);
      end
      // Back-to-back loads: the later word must win
      load(14'h1e80, 1'b0);
      load(14'h0080, 1'b0);
      verify(14'h0080);
      @(posedge mclk_i);
      conv_req <= 1'b1;
      @(posedge mclk_i);
      conv_req <= 1'b0;
      for (k = 0; k < 20 && conv !== 1'b1; k++) begin
         @(posedge mclk_i);
      end
      if (conv !== 1'b1) begin
         n_fail++;
      end else begin
         // A load in mid-conversion must wait for the next acquisition
         load(14'h1b40, 1'b0);
         verify(14'h0080);
         @(posedge mclk_i);
         done <= 1'b1;
         @(posedge mclk_i);
         done <= 1'b0;
         verify(14'h1b40);
         check("converting", 11'(conv), 11'h000);
      end
      conclude();
   end
endmodule
